// file: timer_status_irq_flags_tb.sv
// Self-checking bench for the timer event flag and interrupt enable block
module timer_status_irq_flags_tb import tsf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, standby = 0, pcs = 0, cm1 = 0, cm0 = 0, rd_pend = 0;
  logic [NUM_DMA_CH-1:0] dma = '0;
  tsf_evt_t evt = '0;
  tsf_bus_t bus;
  logic [15:0] rdata;
  logic [NUM_CH-1:0] irq_a, irq_b, irq_w;
  logic [NUM_CH-1:0][NUM_WIDE-1:0][15:0] wide;
  logic [15:0] exp_q[$];
  int err_count = 0, num_checks = 0;
  initial forever #12.5 clk = ~clk;
  tsf_cpu_model i_tsf_cpu_model (.clk(clk), .bus(bus));
  tsf_status_irq i_tsf_status_irq (.clk(clk), .reset(reset), .standby(standby), .bus(bus),
    .rdata(rdata), .evt(evt), .phase_count_select(pcs), .combined_mode_bit1(cm1),
    .combined_mode_bit0(cm0), .dma_start_a(dma), .match_capture_irq_a(irq_a),
    .match_capture_irq_b(irq_b), .wrap_irq(irq_w), .wide_regs(wide));
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask
  // Reads note their expected data; the monitor compares it one cycle later
  task automatic rd(logic [6:0] a, logic [1:0] be, logic [15:0] e);
    exp_q.push_back(e);
    i_tsf_cpu_model.access(1'b1, a, be, 16'h0000);
  endtask
  task automatic wr(logic [6:0] a, logic [1:0] be, logic [15:0] d);
    i_tsf_cpu_model.access(1'b0, a, be, d);
  endtask
  task automatic pulse(tsf_evt_t v, logic [3:0] d);
    @(negedge clk);
    evt <= v;
    dma <= d;
    @(negedge clk);
    evt <= '0;
    dma <= '0;
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Read data stands for one cycle after the read edge
  always @(posedge clk) rd_pend <= bus.rd;
  always @(negedge clk) begin
    if (rd_pend) chk("rdata", exp_q.pop_front(), rdata);
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    print_verdict();
  end
  initial begin
    logic [6:0] fa;
    logic [15:0] w;
    tsf_evt_t ev;
    void'($urandom(32'h054d));
    repeat (10) @(negedge clk);
    reset <= 0;
    pcs <= 1;
    cm1 <= 1;
    for (int c = 0; c < NUM_CH; c++) begin
      fa = 7'(c * 16 + 10);
      rd(fa, 2'b10, 16'h7800);
      rd(fa + 7'h1, 2'b01, 16'h0078);
      wr(fa + 7'h1, 2'b01, 16'h0085);
      rd(fa + 7'h1, 2'b01, 16'h007d);
      ev = '0;
      ev.wrap_up[c] = 1;
      ev.match_a[c] = 1;
      ev.match_b[c] = 1;
      pulse(ev, 4'h0);
      chk("irq", 16'h0005, {13'h0, irq_w[c], irq_b[c], irq_a[c]});
      rd(fa, 2'b10, 16'h7f00);
      wr(fa, 2'b10, 16'h0600);
      wr(fa, 2'b10, 16'h0000);
      rd(fa, 2'b10, 16'h7e00);
      wr(fa, 2'b10, 16'h0000);
      chk("irq", 16'h0000, {13'h0, irq_w[c], irq_b[c], irq_a[c]});
      ev = '0;
      ev.match_a[c] = 1;
      ev.wrap_down[c] = 1;
      pulse(ev, 4'h0);
      pulse('0, 4'(c < NUM_DMA_CH ? 1 << c : 0));
      rd(fa, 2'b10, 16'h7800 | (c >= 2 ? 16'h0400 : 16'h0) | (c == 4 ? 16'h0100 : 16'h0));
    end
    // Standby wipes flags and enables left set on the last channel
    @(negedge clk);
    standby <= 1;
    @(negedge clk);
    standby <= 0;
    rd(7'h4a, 2'b10, 16'h7800);
    rd(7'h4b, 2'b01, 16'h0078);
    // Leave both up-down modes: downward wraps must now be ignored
    pcs <= 0;
    cm0 <= 1;
    ev = '0;
    ev.wrap_down = 5'h1c;
    pulse(ev, 4'h0);
    rd(7'h2a, 2'b10, 16'h7800);
    rd(7'h3a, 2'b10, 16'h7800);
    w = 16'($urandom);
    wr(7'h12, 2'b11, w);
    wr(7'h12, 2'b10, ~w);
    rd(7'h12, 2'b11, {~w[15:8], w[7:0]});
    chk("wide", {~w[15:8], w[7:0]}, wide[1][1]);
    rd(7'h5a, 2'b10, 16'h0000);
    repeat (3) @(negedge clk);
    chk("queue", 16'h0000, 16'(exp_q.size()));
    print_verdict();
  end
endmodule

// file: tsf_cpu_model.sv
// CPU-side bus model that issues single byte or word cycles
module tsf_cpu_model
  import tsf_pkg::*;
(
  // Clock
  input wire logic clk,
  // Bus cycle towards the block
  output tsf_bus_t bus
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bus = '0;
  // One edge per access; released lines invert so stale values never look valid
  task automatic access(input logic r, input logic [6:0] a, input logic [1:0] be,
                        input logic [15:0] d);
    logic [15:0] wd;
    wd = (a[3:1] == IDX_FLAGS_ENABLES) ? (d | 16'h7878) : d;
    @(negedge clk);
    bus <= '{rd: r, wr: !r, be: be, addr: a, wdata: wd};
    @(negedge clk);
    bus <= '{rd: 1'b0, wr: 1'b0, be: ~be, addr: ~a, wdata: ~wd};
  endtask
endmodule

// file: tsf_pkg.sv
// Constants and types for the timer status flag and interrupt enable block
package tsf_pkg;
  localparam int NUM_CH = 5;
  localparam int NUM_DMA_CH = 4;
  localparam int NUM_WIDE = 5;
  localparam int ADDR_W = 7;
  // Channel select is addr[6:4]; word index is addr[3:1]
  localparam int CH_LSB = 4;
  localparam int IDX_LSB = 1;
  localparam logic [2:0] IDX_COUNTER = 3'h0;
  localparam logic [2:0] IDX_GEN_A = 3'h1;
  localparam logic [2:0] IDX_GEN_B = 3'h2;
  localparam logic [2:0] IDX_BUF_A = 3'h3;
  localparam logic [2:0] IDX_BUF_B = 3'h4;
  // Flags in the even byte (upper lane), enables in the odd byte
  localparam logic [2:0] IDX_FLAGS_ENABLES = 3'h5;
  localparam logic [2:0] LAST_CH = 3'h4;
  // Field positions shared by flags and enables
  localparam int BIT_WRAP = 2;
  localparam int BIT_B = 1;
  localparam int BIT_A = 0;
  localparam int LANE_HI = 1;
  localparam int LANE_LO = 0;
  // Reset value of the three live bits; reserved bits are constants
  localparam logic [2:0] LIVE_RESET = 3'h0;
  localparam logic [3:0] RSVD_ONES = 4'hf;
  localparam logic RSVD_TOP = 1'h0;
  localparam logic [15:0] WIDE_RESET = 16'h0000;

  // One CPU bus cycle; be[1] is the even (upper) byte
  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] be;
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
  } tsf_bus_t;

  // Event pulses from the counting logic, one bit per channel
  typedef struct packed {
    logic [NUM_CH-1:0] wrap_up;
    logic [NUM_CH-1:0] wrap_down;
    logic [NUM_CH-1:0] match_a;
    logic [NUM_CH-1:0] match_b;
  } tsf_evt_t;
endpackage

// file: tsf_status_irq.sv
// Per-channel event flags, interrupt enables and CPU register access
module tsf_status_irq
  import tsf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic standby,
  // CPU register access
  input wire tsf_bus_t bus,
  output logic [15:0] rdata,
  // Events and mode bits from the counting logic
  input wire tsf_evt_t evt,
  input wire logic phase_count_select,
  input wire logic combined_mode_bit1,
  input wire logic combined_mode_bit0,
  input wire logic [NUM_DMA_CH-1:0] dma_start_a,
  // Interrupt requests
  output logic [NUM_CH-1:0] match_capture_irq_a,
  output logic [NUM_CH-1:0] match_capture_irq_b,
  output logic [NUM_CH-1:0] wrap_irq,
  // Register contents for the counting logic
  output logic [NUM_CH-1:0][NUM_WIDE-1:0][15:0] wide_regs
);

  logic [NUM_CH-1:0][2:0] flags_q;
  logic [NUM_CH-1:0][2:0] enables_q;
  logic [NUM_CH-1:0][2:0] armed_q;
  logic [NUM_CH-1:0][NUM_WIDE-1:0][15:0] wide_q;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  // Address decode
  wire logic [2:0] sel_ch = bus.addr[ADDR_W-1:CH_LSB];
  wire logic [2:0] sel_idx = bus.addr[CH_LSB-1:IDX_LSB];
  wire logic ch_ok = (sel_ch <= LAST_CH);
  wire logic is_fe = ch_ok && (sel_idx == IDX_FLAGS_ENABLES);
  wire logic is_wide = ch_ok && (sel_idx < IDX_FLAGS_ENABLES);
  wire logic flags_rd = bus.rd && is_fe && bus.be[LANE_HI];
  wire logic flags_wr = bus.wr && is_fe && bus.be[LANE_HI];
  wire logic enables_wr = bus.wr && is_fe && bus.be[LANE_LO];

  // Downward wraps only count where the counter runs both ways
  wire logic [NUM_CH-1:0] down_ok = {
    {2{combined_mode_bit1 && !combined_mode_bit0}}, phase_count_select, 2'b00};

  assign wide_regs = wide_q;
  assign rdata = rdata_q;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic hit;
      logic [2:0] set_ev;
      logic [2:0] clr_ev;
      logic dma_clr;
      assign hit = (sel_ch == 3'(ch));
      // Hardware sets; listed so a clear in the same cycle loses
      assign set_ev[BIT_WRAP] = evt.wrap_up[ch] || (evt.wrap_down[ch] && down_ok[ch]);
      assign set_ev[BIT_B] = evt.match_b[ch];
      assign set_ev[BIT_A] = evt.match_a[ch];
      if (ch < NUM_DMA_CH) begin : g_dma
        assign dma_clr = dma_start_a[ch];
      end else begin : g_nodma
        assign dma_clr = 1'b0;
      end
      // Clear needs an earlier read that saw the bit at one
      assign clr_ev = (flags_wr && hit) ? (armed_q[ch] & ~bus.wdata[10:8]) : 3'h0;
      assign wrap_irq[ch] = flags_q[ch][BIT_WRAP] && enables_q[ch][BIT_WRAP];
      assign match_capture_irq_b[ch] = flags_q[ch][BIT_B] && enables_q[ch][BIT_B];
      assign match_capture_irq_a[ch] = flags_q[ch][BIT_A] && enables_q[ch][BIT_A];

      // Flags, set wins over any clear
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          flags_q[ch] <= LIVE_RESET;
        end else if (standby) begin
          flags_q[ch] <= LIVE_RESET;
        end else begin
          flags_q[ch] <= (flags_q[ch] & ~clr_ev & ~{2'b00, dma_clr}) | set_ev;
        end
      end

      // Read-as-one memory; any flags write consumes it
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          armed_q[ch] <= LIVE_RESET;
        end else if (standby || (flags_wr && hit)) begin
          armed_q[ch] <= LIVE_RESET;
        end else if (flags_rd && hit) begin
          armed_q[ch] <= flags_q[ch];
        end
      end

      // Enables; reserved bits written are ignored
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          enables_q[ch] <= LIVE_RESET;
        end else if (standby) begin
          enables_q[ch] <= LIVE_RESET;
        end else if (enables_wr && hit) begin
          enables_q[ch] <= bus.wdata[2:0];
        end
      end

      // Sixteen-bit registers, each byte lane written on its own
      for (genvar r = 0; r < NUM_WIDE; r++) begin : g_wide
        logic wr_r;
        assign wr_r = bus.wr && is_wide && hit && (sel_idx == 3'(r));
        always_ff @(posedge clk or posedge reset) begin
          if (reset) begin
            wide_q[ch][r] <= WIDE_RESET;
          end else if (wr_r) begin
            if (bus.be[LANE_HI]) begin
              wide_q[ch][r][15:8] <= bus.wdata[15:8];
            end
            if (bus.be[LANE_LO]) begin
              wide_q[ch][r][7:0] <= bus.wdata[7:0];
            end
          end
        end
      end
    end
  endgenerate

  // Read mux; unmapped addresses read zero, unselected lanes read zero
  always_comb begin
    rdata_d = 16'h0000;
    if (bus.rd && is_wide) begin
      rdata_d = wide_q[sel_ch][sel_idx];
    end else if (bus.rd && is_fe) begin
      // Reserved bits read one; the undefined top bit reads zero here
      rdata_d = {RSVD_TOP, RSVD_ONES, flags_q[sel_ch], RSVD_TOP, RSVD_ONES, enables_q[sel_ch]};
    end
    rdata_d[15:8] = bus.be[LANE_HI] ? rdata_d[15:8] : 8'h00;
    rdata_d[7:0] = bus.be[LANE_LO] ? rdata_d[7:0] : 8'h00;
  end

  // Read data is registered, so it appears one cycle after the strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  wire logic ch0_flags_wr = flags_wr && (sel_ch == 3'h0) && !standby;
  // Upper-byte-only write to channel 1 register A, the case the bench drives
  wire logic ch1_hi_wr = bus.wr && is_wide && (sel_ch == 3'h1) && (sel_idx == IDX_GEN_A)
    && (bus.be == 2'b10);
  wire logic ch1_word_acc = is_wide && (sel_ch == 3'h1) && (sel_idx == IDX_GEN_A)
    && (bus.be == 2'b11);

  chk_wrap_up_set: assert property (evt.wrap_up[1] && !standby |=> flags_q[1][BIT_WRAP])
    else $error("wrap flag not set after upward wrap");
  chk_down_blocked: assert property (evt.wrap_down[0] && !evt.wrap_up[0] && !flags_q[0][BIT_WRAP]
    |=> !flags_q[0][BIT_WRAP])
    else $error("downward wrap set flag on a one-way channel");
  chk_clear_needs_read: assert property (ch0_flags_wr && !armed_q[0][BIT_A] && flags_q[0][BIT_A]
    && !dma_start_a[0] |=> flags_q[0][BIT_A])
    else $error("flag cleared without a prior read");
  chk_read_then_clear: assert property (flags_rd && sel_ch == 3'h2 && flags_q[2][BIT_B]
    && !standby ##1 (!bus.wr && !standby) ##1 (flags_wr && sel_ch == 3'h2 && !bus.wdata[9]
    && !evt.match_b[2]
    && !standby) |=> !flags_q[2][BIT_B])
    else $error("read-then-write-zero did not clear");
  chk_match_b_set: assert property (evt.match_b[3] && !standby |=> flags_q[3][BIT_B])
    else $error("flag B not set on match or capture");
  chk_match_a_set: assert property (evt.match_a[4] && !standby |=> flags_q[4][BIT_A])
    else $error("flag A not set on match or capture");
  chk_dma_clear_a: assert property (dma_start_a[1] && !evt.match_a[1] |=> !flags_q[1][BIT_A])
    else $error("DMA start did not clear flag A");
  chk_irq_blocked: assert property (!enables_q[2][BIT_B] |-> !match_capture_irq_b[2])
    else $error("request passed a disabled enable");
  chk_standby_init: assert property (standby |=> flags_q[0] == LIVE_RESET
    && enables_q[0] == LIVE_RESET)
    else $error("standby did not initialise flags and enables");
  chk_reserved_ones: assert property (bus.rd && is_fe && bus.be[LANE_HI]
    |=> rdata[14:11] == RSVD_ONES)
    else $error("reserved flag bits did not read one");
  chk_reserved_lo: assert property (bus.rd && is_fe && bus.be[LANE_LO]
    |=> rdata[6:3] == RSVD_ONES)
    else $error("reserved enable bits did not read one");
  chk_byte_half: assert property (ch1_hi_wr |=> wide_q[1][1][7:0] == $past(wide_q[1][1][7:0]))
    else $error("upper byte write disturbed lower half");

  // Setting events on more channels (wrap 0, 2, 4; B 0, 1, 4; A 0, 2); standby would mask them
  // Upward wrap on channel 0
  chk_wrap_up_ch0: assert property (evt.wrap_up[0] && !standby
    |=> flags_q[0][BIT_WRAP])
    else $error("wrap flag 0 not set after upward wrap");
  // Upward wrap on channel 2
  chk_wrap_up_ch2: assert property (evt.wrap_up[2] && !standby
    |=> flags_q[2][BIT_WRAP])
    else $error("wrap flag 2 not set after upward wrap");
  // Upward wrap on channel 4
  chk_wrap_up_ch4: assert property (evt.wrap_up[4] && !standby
    |=> flags_q[4][BIT_WRAP])
    else $error("wrap flag 4 not set after upward wrap");
  // Compare or capture B on channel 0
  chk_match_b_ch0: assert property (evt.match_b[0] && !standby
    |=> flags_q[0][BIT_B])
    else $error("flag B 0 not set");
  // Capture into B on channel 1
  chk_match_b_ch1: assert property (evt.match_b[1] && !standby
    |=> flags_q[1][BIT_B])
    else $error("flag B 1 not set");
  // Capture into B on channel 4
  chk_match_b_ch4: assert property (evt.match_b[4] && !standby
    |=> flags_q[4][BIT_B])
    else $error("flag B 4 not set");
  // Compare or capture A on channel 0
  chk_match_a_ch0: assert property (evt.match_a[0] && !standby
    |=> flags_q[0][BIT_A])
    else $error("flag A 0 not set");
  // Compare or capture A on channel 2
  chk_match_a_ch2: assert property (evt.match_a[2] && !standby
    |=> flags_q[2][BIT_A])
    else $error("flag A 2 not set");

  // Downward wraps count only where the counter runs both ways
  // Channel 2 in phase counting
  chk_down_ch2_set: assert property (evt.wrap_down[2] && phase_count_select && !standby
    |=> flags_q[2][BIT_WRAP])
    else $error("downward wrap ignored in phase counting");
  // Channel 4 in complementary mode
  chk_down_ch4_set: assert property (evt.wrap_down[4] && combined_mode_bit1
    && !combined_mode_bit0 && !standby |=> flags_q[4][BIT_WRAP])
    else $error("downward wrap ignored in complementary mode");
  // Channel 1 never counts down
  chk_down_ch1_blocked: assert property (evt.wrap_down[1] && !evt.wrap_up[1]
    && !flags_q[1][BIT_WRAP] |=> !flags_q[1][BIT_WRAP])
    else $error("downward wrap set flag on channel 1");
  // Channel 3 outside complementary mode
  chk_down_ch3_mode: assert property (evt.wrap_down[3] && !evt.wrap_up[3] && combined_mode_bit0
    && !flags_q[3][BIT_WRAP] |=> !flags_q[3][BIT_WRAP])
    else $error("downward wrap set flag outside complementary mode");

  // Clearing paths: software sequence and DMA
  // DMA start on channel 3 clears A
  chk_dma_clear_ch3: assert property (dma_start_a[3] && !evt.match_a[3]
    |=> !flags_q[3][BIT_A])
    else $error("DMA start did not clear flag A 3");
  // Channel 4 has no DMA clear, so A holds until software clears it
  chk_dma_keep_ch4: assert property (flags_q[4][BIT_A] && !standby
    && !(flags_wr && sel_ch == 3'h4) |=> flags_q[4][BIT_A])
    else $error("flag A 4 lost without a clear");
  // Writing one never sets a flag
  chk_write_no_set: assert property (flags_wr && sel_ch == 3'h1 && !flags_q[1][BIT_B]
    && !evt.match_b[1] |=> !flags_q[1][BIT_B])
    else $error("flag write set flag B 1");
  // A write without a prior read leaves the wrap flag
  chk_clear_needs_read_ch3: assert property (flags_wr && sel_ch == 3'h3
    && !armed_q[3][BIT_WRAP] && flags_q[3][BIT_WRAP] && !standby |=> flags_q[3][BIT_WRAP])
    else $error("wrap flag 3 cleared without a prior read");

  // Request gating
  // Disabled wrap request stays low
  chk_wrap_gate_ch4: assert property (!enables_q[4][BIT_WRAP]
    |-> !wrap_irq[4])
    else $error("wrap request passed a disabled enable");
  // Disabled B request stays low
  chk_b_gate_ch0: assert property (!enables_q[0][BIT_B]
    |-> !match_capture_irq_b[0])
    else $error("B request passed a disabled enable");
  // Enabled A flag raises its request
  chk_a_pass_ch1: assert property (flags_q[1][BIT_A] && enables_q[1][BIT_A]
    |-> match_capture_irq_a[1])
    else $error("enabled A flag gave no request");
  // Enabled wrap flag raises its request
  chk_wrap_pass_ch3: assert property (flags_q[3][BIT_WRAP] && enables_q[3][BIT_WRAP]
    |-> wrap_irq[3])
    else $error("enabled wrap flag gave no request");

  // Initialisation and sixteen-bit access
  // Standby on the last channel
  chk_standby_ch4: assert property (standby
    |=> flags_q[4] == LIVE_RESET && enables_q[4] == LIVE_RESET)
    else $error("standby did not initialise channel 4");
  // Word write lands whole
  chk_word_write: assert property (bus.wr && ch1_word_acc
    |=> wide_q[1][1] == $past(bus.wdata))
    else $error("word write did not land");
  // Word read returns the whole register
  chk_word_read: assert property (bus.rd && ch1_word_acc
    |=> rdata == $past(wide_q[1][1]))
    else $error("word read returned wrong data");

  cov_wrap_irq: cover property (enables_q[0][BIT_WRAP] ##1 wrap_irq[0]);
  cov_clear_seq: cover property (flags_rd && sel_ch == 3'h1 && flags_q[1][BIT_A]
    ##2 (flags_wr && sel_ch == 3'h1));
  cov_down_wrap: cover property (evt.wrap_down[2] && phase_count_select);
  cov_set_beats_clear: cover property (flags_wr && evt.match_a[sel_ch]);
  cov_dma_clear: cover property (dma_start_a[0] && flags_q[0][BIT_A]);

endmodule
